//--- design/oaddr_core.sv
// Operation
// - An indexed pointer is the selected index register plus the byte after the opcode.
// - Forming an indexed pointer never writes the index register; the sum only feeds the address.
// - The displacement is a signed byte, sign-extended before the 16-bit add.
// - There are two separate index registers and the prefix byte picks which one is used.
// - Register operands are named by the 3-bit fields inside the opcode.
// - Arithmetic results go to the accumulator, except ALU_CP which writes only the zero flag; no destination field is decoded.
// - Register-indirect operands use a 16-bit register pair as the memory address.
// - A 16-bit pointer read takes the low byte at the pointer and the high byte one above.
// - Bit ops reach register, indirect or indexed operands; a 3-bit field picks the bit.
// - Source and destination of one instruction may use different addressing modes.
// - Opcode 48H copies the first general register into the second after the fetch.
// - Opcode 72 stores the third general register into memory at the pointer pair.
// - Each opcode except the last byte of an indexed bit op is fetched in the fetch cycle, decoded, then executed without help.
// - In extended immediate or address forms the first byte is low order, the next high order.
// - In indexed forms the displacement follows the opcode bytes, before any immediate; in indexed bit ops it comes before the last opcode byte.
`timescale 1ns/1ns
`default_nettype none
module oaddr_core
    import oaddr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    output logic [15:0] mem_addr,
    output logic mem_rd_en,
    output logic mem_wr_en,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ready,
    output logic opcode_fetch_cycle,
    output logic instr_done,
    output logic bit_zero
);
    typedef struct packed {
        logic rd;
        logic wr;
        logic disp;
        logic wide;
        logic [1:0] nimm;
    } oaddr_dec_t;

    typedef struct packed {
        oaddr_state_t st;
        logic [15:0] pc;
        logic [7:0] op;
        oaddr_idx_t idx;
        logic cb;
        logic [7:0] disp;
        logic [7:0] imm_lo;
        logic [7:0] imm_hi;
        logic [7:0] data;
        logic [7:0] data_hi;
        logic [15:0] ptr;
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic fc;
        logic done;
        logic zero;
    } oaddr_core_t;

    oaddr_core_t s_q;
    oaddr_core_t s_d;
    oaddr_rf_if rf ();
    logic [15:0] idx_base;
    logic [15:0] idx_ea;
    logic [15:0] ptr_c;
    logic [2:0] mp_pair;
    oaddr_dec_t dq;
    oaddr_dec_t dn;
    logic [7:0] src_v;
    logic [7:0] mask;
    logic [7:0] res;
    logic cb_mem;
    logic busy;

    // Operand needs of one opcode byte
    function automatic oaddr_dec_t decode(input logic [7:0] op, input logic cb,
                                          input oaddr_idx_t idx);
        oaddr_dec_t d;
        logic src_m;
        logic dst_m;
        logic mem;
        d = '0;
        src_m = (op[F_GRP_HI:F_GRP_LO] == GRP_LOAD && op[F_SRC_HI:F_SRC_LO] == REG_MEM &&
                 op != OP_HALT_SLOT) ||
                (op[F_GRP_HI:F_GRP_LO] == GRP_ALU && op[F_SRC_HI:F_SRC_LO] == REG_MEM);
        dst_m = (op[F_GRP_HI:F_GRP_LO] == GRP_LOAD && op[F_DST_HI:F_DST_LO] == REG_MEM &&
                 op != OP_HALT_SLOT) || op == OP_MV_MEM_IMM;
        mem = idx != IDX_NONE || op[F_SRC_HI:F_SRC_LO] == REG_MEM;
        if (cb) begin
            d.rd = mem;
            d.wr = mem && op[F_GRP_HI:F_GRP_LO] != CB_TEST;
        end else begin
            d.disp = idx != IDX_NONE && (src_m || dst_m);
            d.rd = src_m || op == OP_MV_A_BC || op == OP_MV_A_DE || op == OP_MV_A_EXT ||
                   op == OP_MV_PTR_EXT;
            d.wr = dst_m || op == OP_MV_BC_A || op == OP_MV_DE_A || op == OP_MV_EXT_A;
            d.wide = op == OP_MV_PTR_EXT;
            if (op[F_GRP_HI:F_GRP_LO] == GRP_MISC && op[F_SRC_HI:F_SRC_LO] == REG_MEM) begin
                d.nimm = 2'd1;
            end else if (op == OP_MV_A_EXT || op == OP_MV_EXT_A || op == OP_MV_PTR_EXT ||
                         op == OP_MV_BC_IMM || op == OP_MV_DE_IMM || op == OP_MV_PTR_IMM) begin
                d.nimm = 2'd2;
            end
        end
        return d;
    endfunction

    // Next stage once the given number of immediate bytes is in
    function automatic oaddr_state_t route(input oaddr_dec_t d, input logic [1:0] got);
        oaddr_state_t n;
        if (got < d.nimm) begin
            n = (got == 2'd0) ? ST_IMM_LO : ST_IMM_HI;
        end else if (d.rd) begin
            n = ST_RD;
        end else begin
            n = ST_EXEC;
        end
        return n;
    endfunction

    oaddr_regfile u_regfile (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .rf(rf.rf)
    );

    // Prefix selects which index register feeds the adder
    assign idx_base = (s_q.idx == IDX_SECOND) ? rf.xb : rf.xa;

    oaddr_ea_calc u_ea (
        .base(idx_base),
        .disp(s_q.disp),
        .ea(idx_ea)
    );

    // Operand pointer by addressing mode
    always_comb begin
        mp_pair = (s_q.idx == IDX_FIRST) ? PAIR_XA :
                  (s_q.idx == IDX_SECOND) ? PAIR_XB : PAIR_MP;
        if (!s_q.cb && (s_q.op == OP_MV_A_EXT || s_q.op == OP_MV_EXT_A ||
                        s_q.op == OP_MV_PTR_EXT)) begin
            ptr_c = {s_q.imm_hi, s_q.imm_lo};
        end else if (s_q.idx != IDX_NONE) begin
            ptr_c = idx_ea;
        end else if (!s_q.cb && (s_q.op == OP_MV_A_BC || s_q.op == OP_MV_BC_A)) begin
            ptr_c = rf.bc;
        end else if (!s_q.cb && (s_q.op == OP_MV_A_DE || s_q.op == OP_MV_DE_A)) begin
            ptr_c = rf.de;
        end else begin
            ptr_c = rf.mp;
        end
    end

    // Decode of the held opcode and of the byte now arriving
    always_comb begin
        dq = decode(s_q.op, s_q.cb, s_q.idx);
        dn = decode(mem_rdata, s_q.cb, s_q.idx);
        cb_mem = s_q.idx != IDX_NONE || s_q.op[F_SRC_HI:F_SRC_LO] == REG_MEM;
        src_v = (s_q.op[F_SRC_HI:F_SRC_LO] == REG_MEM || (s_q.cb && cb_mem)) ?
                s_q.data : rf.src_val;
        mask = 8'h01 << s_q.op[F_DST_HI:F_DST_LO];
        busy = s_q.rd || s_q.wr;
    end

    // Sequencer: fetch, displacement, immediates, read, execute, write
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        res = 8'h00;
        rf.src_sel = s_q.op[F_SRC_HI:F_SRC_LO];
        rf.w8_en = 1'b0;
        rf.w8_sel = s_q.op[F_DST_HI:F_DST_LO];
        rf.w8_data = src_v;
        rf.w16_en = 1'b0;
        rf.w16_sel = PAIR_BC;
        rf.w16_data = {s_q.imm_hi, s_q.imm_lo};
        case (s_q.st)
            ST_FETCH, ST_CBOP, ST_DISP, ST_IMM_LO, ST_IMM_HI: begin
                if (!busy && (run || s_q.st != ST_FETCH)) begin
                    s_d.rd = 1'b1;
                    s_d.addr = s_q.pc;
                    s_d.fc = s_q.st == ST_FETCH ||
                             (s_q.st == ST_CBOP && s_q.idx == IDX_NONE);
                end else if (s_q.rd && mem_ready) begin
                    s_d.rd = 1'b0;
                    s_d.fc = 1'b0;
                    s_d.pc = s_q.pc + PTR_STEP;
                    case (s_q.st)
                        ST_FETCH: begin
                            if (mem_rdata == OP_PFX_FIRST) begin
                                s_d.idx = IDX_FIRST;
                            end else if (mem_rdata == OP_PFX_SECOND) begin
                                s_d.idx = IDX_SECOND;
                            end else if (mem_rdata == OP_PFX_BIT) begin
                                s_d.cb = 1'b1;
                                s_d.st = (s_q.idx != IDX_NONE) ? ST_DISP : ST_CBOP;
                            end else begin
                                s_d.op = mem_rdata;
                                s_d.st = dn.disp ? ST_DISP : route(dn, 2'd0);
                            end
                        end
                        ST_CBOP: begin
                            s_d.op = mem_rdata;
                            s_d.st = dn.rd ? ST_RD : ST_EXEC;
                        end
                        ST_DISP: begin
                            s_d.disp = mem_rdata;
                            s_d.st = s_q.cb ? ST_CBOP : route(dq, 2'd0);
                        end
                        ST_IMM_LO: begin
                            s_d.imm_lo = mem_rdata;
                            s_d.st = route(dq, 2'd1);
                        end
                        default: begin
                            s_d.imm_hi = mem_rdata;
                            s_d.st = route(dq, 2'd2);
                        end
                    endcase
                end
            end
            ST_RD, ST_RD_HI: begin
                if (!busy) begin
                    s_d.rd = 1'b1;
                    s_d.ptr = (s_q.st == ST_RD) ? ptr_c : s_q.ptr + PTR_STEP;
                    s_d.addr = s_d.ptr;
                end else if (mem_ready) begin
                    s_d.rd = 1'b0;
                    if (s_q.st == ST_RD) begin
                        s_d.data = mem_rdata;
                        s_d.st = dq.wide ? ST_RD_HI : ST_EXEC;
                    end else begin
                        s_d.data_hi = mem_rdata;
                        s_d.st = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                if (s_q.cb) begin
                    case (s_q.op[F_GRP_HI:F_GRP_LO])
                        CB_TEST: res = src_v;
                        CB_CLR: res = src_v & ~mask;
                        CB_SET: res = src_v | mask;
                        default: res = src_v;
                    endcase
                    if (s_q.op[F_GRP_HI:F_GRP_LO] == CB_TEST) begin
                        s_d.zero = ~|(src_v & mask);
                    end
                    rf.w8_sel = s_q.op[F_SRC_HI:F_SRC_LO];
                    rf.w8_data = res;
                    rf.w8_en = !cb_mem && s_q.op[F_GRP_HI:F_GRP_LO] != CB_TEST;
                    s_d.wdata = res;
                end else begin
                    case (s_q.op[F_GRP_HI:F_GRP_LO])
                        GRP_LOAD: begin
                            // 48H lands here as a plain copy, 72 as a store of the third general register at the pointer pair
                            if (s_q.op[F_DST_HI:F_DST_LO] == REG_MEM) begin
                                s_d.wdata = src_v;
                            end else begin
                                rf.w8_en = 1'b1;
                            end
                        end
                        GRP_ALU: begin
                            case (s_q.op[F_DST_HI:F_DST_LO])
                                ALU_ADD, ALU_ADC: res = rf.acc + src_v;
                                ALU_SUB, ALU_SBC, ALU_CP: res = rf.acc - src_v;
                                ALU_AND: res = rf.acc & src_v;
                                ALU_XOR: res = rf.acc ^ src_v;
                                ALU_OR: res = rf.acc | src_v;
                                default: res = src_v;
                            endcase
                            s_d.zero = res == 8'h00;
                            rf.w8_sel = REG_A;
                            rf.w8_data = res;
                            rf.w8_en = s_q.op[F_DST_HI:F_DST_LO] != ALU_CP;
                        end
                        GRP_MISC: begin
                            case (s_q.op)
                                OP_MV_A_BC, OP_MV_A_DE, OP_MV_A_EXT: begin
                                    rf.w8_sel = REG_A;
                                    rf.w8_data = s_q.data;
                                    rf.w8_en = 1'b1;
                                end
                                OP_MV_BC_A, OP_MV_DE_A, OP_MV_EXT_A: s_d.wdata = rf.acc;
                                OP_MV_PTR_EXT: begin
                                    rf.w16_sel = mp_pair;
                                    rf.w16_data = {s_q.data_hi, s_q.data};
                                    rf.w16_en = 1'b1;
                                end
                                OP_MV_BC_IMM: rf.w16_en = 1'b1;
                                OP_MV_DE_IMM: begin
                                    rf.w16_sel = PAIR_DE;
                                    rf.w16_en = 1'b1;
                                end
                                OP_MV_PTR_IMM: begin
                                    rf.w16_sel = mp_pair;
                                    rf.w16_en = 1'b1;
                                end
                                default: begin
                                    // Immediate source into register or memory
                                    if (s_q.op[F_SRC_HI:F_SRC_LO] == REG_MEM) begin
                                        rf.w8_data = s_q.imm_lo;
                                        rf.w8_en = s_q.op[F_DST_HI:F_DST_LO] != REG_MEM;
                                        s_d.wdata = s_q.imm_lo;
                                    end
                                end
                            endcase
                        end
                        default: res = 8'h00;
                    endcase
                end
                if (dq.wr) begin
                    s_d.st = ST_WR;
                end else begin
                    s_d.st = ST_FETCH;
                    s_d.idx = IDX_NONE;
                    s_d.cb = 1'b0;
                    s_d.done = 1'b1;
                end
            end
            ST_WR: begin
                if (!busy) begin
                    s_d.wr = 1'b1;
                    s_d.addr = ptr_c;
                end else if (mem_ready) begin
                    s_d.wr = 1'b0;
                    s_d.st = ST_FETCH;
                    s_d.idx = IDX_NONE;
                    s_d.cb = 1'b0;
                    s_d.done = 1'b1;
                end
            end
            default: s_d.st = ST_FETCH;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{st: ST_FETCH, pc: RST_PC, idx: IDX_NONE, ptr: RST_REG16,
                     addr: RST_REG16, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign mem_addr = s_q.addr;
    assign mem_rd_en = s_q.rd;
    assign mem_wr_en = s_q.wr;
    assign mem_wdata = s_q.wdata;
    assign opcode_fetch_cycle = s_q.fc;
    assign instr_done = s_q.done;
    assign bit_zero = s_q.zero;
endmodule
`default_nettype wire

//--- design/oaddr_pkg.sv
`default_nettype none
package oaddr_pkg;
    // Opcode encodings
    localparam logic [7:0] OP_PFX_FIRST = 8'hDD;
    localparam logic [7:0] OP_PFX_SECOND = 8'hFD;
    localparam logic [7:0] OP_PFX_BIT = 8'hCB;
    localparam logic [7:0] OP_MV_A_BC = 8'h0A;
    localparam logic [7:0] OP_MV_A_DE = 8'h1A;
    localparam logic [7:0] OP_MV_BC_A = 8'h02;
    localparam logic [7:0] OP_MV_DE_A = 8'h12;
    localparam logic [7:0] OP_MV_A_EXT = 8'h3A;
    localparam logic [7:0] OP_MV_EXT_A = 8'h32;
    localparam logic [7:0] OP_MV_PTR_EXT = 8'h2A;
    localparam logic [7:0] OP_MV_BC_IMM = 8'h01;
    localparam logic [7:0] OP_MV_DE_IMM = 8'h11;
    localparam logic [7:0] OP_MV_PTR_IMM = 8'h21;
    localparam logic [7:0] OP_MV_MEM_IMM = 8'h36;
    localparam logic [7:0] OP_HALT_SLOT = 8'h76;
    // Opcode field positions
    localparam int F_SRC_LO = 0;
    localparam int F_SRC_HI = 2;
    localparam int F_DST_LO = 3;
    localparam int F_DST_HI = 5;
    localparam int F_GRP_LO = 6;
    localparam int F_GRP_HI = 7;
    // Register codes in the 3-bit fields
    localparam logic [2:0] REG_B = 3'h0;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A = 3'h7;
    // Major groups, and bit-group codes after the bit prefix
    localparam logic [1:0] GRP_MISC = 2'h0;
    localparam logic [1:0] GRP_LOAD = 2'h1;
    localparam logic [1:0] GRP_ALU = 2'h2;
    localparam logic [1:0] CB_TEST = 2'h1;
    localparam logic [1:0] CB_CLR = 2'h2;
    localparam logic [1:0] CB_SET = 2'h3;
    // Arithmetic operations in the destination field
    localparam logic [2:0] ALU_ADD = 3'h0;
    localparam logic [2:0] ALU_ADC = 3'h1;
    localparam logic [2:0] ALU_SUB = 3'h2;
    localparam logic [2:0] ALU_SBC = 3'h3;
    localparam logic [2:0] ALU_AND = 3'h4;
    localparam logic [2:0] ALU_XOR = 3'h5;
    localparam logic [2:0] ALU_OR = 3'h6;
    localparam logic [2:0] ALU_CP = 3'h7;
    // 16-bit register pair select codes
    localparam logic [2:0] PAIR_BC = 3'h0;
    localparam logic [2:0] PAIR_DE = 3'h1;
    localparam logic [2:0] PAIR_MP = 3'h2;
    localparam logic [2:0] PAIR_XA = 3'h4;
    localparam logic [2:0] PAIR_XB = 3'h5;
    // Reset values and the pointer step
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [15:0] PTR_STEP = 16'h0001;

    typedef enum logic [1:0] {
        IDX_NONE = 2'b00,
        IDX_FIRST = 2'b01,
        IDX_SECOND = 2'b10
    } oaddr_idx_t;

    typedef enum logic [3:0] {
        ST_FETCH = 4'b0000,
        ST_CBOP = 4'b0001,
        ST_DISP = 4'b0010,
        ST_IMM_LO = 4'b0011,
        ST_IMM_HI = 4'b0100,
        ST_RD = 4'b0101,
        ST_RD_HI = 4'b0110,
        ST_EXEC = 4'b0111,
        ST_WR = 4'b1000
    } oaddr_state_t;
endpackage
`default_nettype wire

//--- design/oaddr_rf_if.sv
`timescale 1ns/1ns
`default_nettype none
// Register file access between the sequencer and the register store
interface oaddr_rf_if;
    logic [2:0] src_sel;
    logic [7:0] src_val;
    logic [7:0] acc;
    logic [15:0] bc;
    logic [15:0] de;
    logic [15:0] mp;
    logic [15:0] xa;
    logic [15:0] xb;
    logic w8_en;
    logic [2:0] w8_sel;
    logic [7:0] w8_data;
    logic w16_en;
    logic [2:0] w16_sel;
    logic [15:0] w16_data;
    modport core (output src_sel, w8_en, w8_sel, w8_data, w16_en, w16_sel, w16_data,
                  input src_val, acc, bc, de, mp, xa, xb);
    modport rf (input src_sel, w8_en, w8_sel, w8_data, w16_en, w16_sel, w16_data,
                output src_val, acc, bc, de, mp, xa, xb);
endinterface
`default_nettype wire

//--- design/oaddr_ea_calc.sv
`timescale 1ns/1ns
`default_nettype none
module oaddr_ea_calc
    import oaddr_pkg::*;
(
    input wire logic [15:0] base,
    input wire logic [7:0] disp,
    output logic [15:0] ea
);
    logic [15:0] disp_ext;
    // Signed displacement, sum wraps in 16 bits, base is only read
    always_comb begin
        disp_ext = {{8{disp[7]}}, disp};
        ea = base + disp_ext;
    end
endmodule
`default_nettype wire

//--- design/oaddr_regfile.sv
`timescale 1ns/1ns
`default_nettype none
module oaddr_regfile
    import oaddr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    oaddr_rf_if.rf rf
);
    typedef struct packed {
        logic [7:0][7:0] r;
        logic [15:0] xa;
        logic [15:0] xb;
    } oaddr_rf_t;

    oaddr_rf_t s_q;
    oaddr_rf_t s_d;

    // Read side: selected source, accumulator and pairs
    assign rf.src_val = s_q.r[rf.src_sel];
    assign rf.acc = s_q.r[REG_A];
    assign rf.bc = {s_q.r[0], s_q.r[1]};
    assign rf.de = {s_q.r[2], s_q.r[3]};
    assign rf.mp = {s_q.r[4], s_q.r[5]};
    assign rf.xa = s_q.xa;
    assign rf.xb = s_q.xb;

    // Write side: the memory slot code has no register behind it
    always_comb begin
        s_d = s_q;
        if (rf.w8_en && rf.w8_sel != REG_MEM) begin
            s_d.r[rf.w8_sel] = rf.w8_data;
        end
        if (rf.w16_en) begin
            case (rf.w16_sel)
                PAIR_BC: {s_d.r[0], s_d.r[1]} = rf.w16_data;
                PAIR_DE: {s_d.r[2], s_d.r[3]} = rf.w16_data;
                PAIR_MP: {s_d.r[4], s_d.r[5]} = rf.w16_data;
                PAIR_XA: s_d.xa = rf.w16_data;
                PAIR_XB: s_d.xb = rf.w16_data;
                default: s_d.xa = s_q.xa;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{r: {8{RST_REG8}}, xa: RST_REG16, xb: RST_REG16};
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

//--- testbench/oaddr_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module oaddr_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd_en,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ready,
    input wire logic opcode_fetch_cycle,
    input wire logic instr_done,
    input wire logic bit_zero
);
    logic [7:0] op_q, pre_q, b0_q, b1_q;
    logic [1:0] n_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Track opcode, prefix and the first two operand bytes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_q <= 8'h00;
            pre_q <= 8'h00;
            b0_q <= 8'h00;
            b1_q <= 8'h00;
            n_q <= 2'h0;
        end else if (mem_rd_en && mem_ready && opcode_fetch_cycle) begin
            pre_q <= op_q;
            op_q <= mem_rdata;
            n_q <= 2'h0;
        end else if (mem_rd_en && mem_ready) begin
            b0_q <= (n_q == 2'h0) ? mem_rdata : b0_q;
            b1_q <= (n_q == 2'h1) ? mem_rdata : b1_q;
            n_q <= (n_q == 2'h3) ? n_q : n_q + 2'h1;
        end
    end
    sequence s_req;
        mem_rd_en || mem_wr_en;
    endsequence
    sequence s_opnd;
        mem_rd_en && !opcode_fetch_cycle;
    endsequence
    chk_fetch_read: assert property (opcode_fetch_cycle |-> mem_rd_en && !mem_wr_en)
        else $error("opcode fetch not a plain read");
    chk_req_hold: assert property (s_req ##0 !mem_ready |=>
        $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_rd_en) && $stable(mem_wr_en))
        else $error("request changed before ready");
    chk_req_drop: assert property (s_req ##0 mem_ready |=> !mem_rd_en && !mem_wr_en)
        else $error("request not dropped after ready");
    chk_done_pulse: assert property (instr_done |=> !instr_done)
        else $error("done longer than one cycle");
    chk_next_fetch: assert property (instr_done && run |-> ##[1:3] opcode_fetch_cycle)
        else $error("no fetch after completion");
    chk_ext_low: assert property (s_opnd ##0 (op_q == 8'h3A || op_q == 8'h2A)
        && n_q == 2'h2 |-> mem_addr == {b1_q, b0_q})
        else $error("extended address byte order wrong");
    chk_pair_high: assert property (s_opnd ##0 op_q == 8'h2A && n_q == 2'h3
        |-> mem_addr == {b1_q, b0_q} + 16'h0001)
        else $error("high byte not at next address");
    chk_ext_store: assert property (mem_wr_en && op_q == 8'h32 |->
        mem_addr == {b1_q, b0_q})
        else $error("extended store address wrong");
    chk_disp_first: assert property (mem_wr_en && op_q == 8'h36 && (pre_q == 8'hDD ||
        pre_q == 8'hFD) |-> mem_wdata == b1_q)
        else $error("immediate not after displacement");
endmodule
bind oaddr_core oaddr_monitor u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .run(run),
    .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .opcode_fetch_cycle(opcode_fetch_cycle), .instr_done(instr_done), .bit_zero(bit_zero));
`default_nettype wire

//--- testbench/oaddr_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module oaddr_tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst, run, mem_rd_en, mem_wr_en, mem_ready, ofc, instr_done, bit_zero, stall_q;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata;
    logic [7:0] mem [0:65535];
    logic [23:0] wq [$];
    int n_errors = 0;
    int n_checks = 0;
    logic [7:0] prog [0:57] = '{8'h21, 8'h34, 8'h12, 8'h16, 8'h55, 8'h72, 8'h06, 8'hA5,
        8'h48, 8'h71, 8'hDD, 8'h21, 8'h00, 8'h10, 8'hDD, 8'h36, 8'hFE, 8'h77, 8'hDD, 8'h36,
        8'h02, 8'h66, 8'hFD, 8'h21, 8'hF0, 8'hFF, 8'hFD, 8'h36, 8'h20, 8'h11, 8'hDD, 8'h70,
        8'h01, 8'h2A, 8'h00, 8'h20, 8'h70, 8'h3E, 8'h0F, 8'h80, 8'h32, 8'h00, 8'h30, 8'hCB,
        8'hC8, 8'hCB, 8'h58, 8'h70, 8'hDD, 8'hCB, 8'h01, 8'h86,
        8'hFD, 8'h7E, 8'h20, 8'h12, 8'hA8, 8'h02};
    oaddr_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .run(run), .mem_addr(mem_addr),
        .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready), .opcode_fetch_cycle(ofc),
        .instr_done(instr_done), .bit_zero(bit_zero));
    always #4 ref_clk = ~ref_clk;
    // Memory answers; even addresses wait one extra cycle
    always @(negedge ref_clk) begin
        mem_ready <= (mem_rd_en | mem_wr_en) & (stall_q | mem_addr[0]);
        stall_q <= mem_rd_en | mem_wr_en;
        mem_rdata <= mem_rd_en ? mem[mem_addr] : ~mem_rdata;
    end
    // Completed writes land in memory and in the write log
    always @(posedge ref_clk) begin
        if (mem_wr_en && mem_ready) begin
            mem[mem_addr] <= mem_wdata;
            wq.push_back({mem_addr, mem_wdata});
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
        n_checks++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask
    // Bounded wait for the next memory write, then compare it
    task automatic expect_wr(input logic [15:0] a, input logic [7:0] d);
        int i;
        i = 0;
        while (wq.size() == 0 && i < 300) begin
            @(negedge ref_clk);
            i++;
        end
        if (wq.size() == 0) begin
            $display("[FAIL] write expected %h seen none", a);
            n_errors++;
            finish_test();
        end else begin
            check("write", {a, d}, wq.pop_front());
        end
    endtask
    task automatic t_pointer();
        expect_wr(16'h1234, 8'h55);
        expect_wr(16'h1234, 8'hA5);
        $display("t_pointer done");
    endtask
    task automatic t_indexed();
        expect_wr(16'h0FFE, 8'h77);
        expect_wr(16'h1002, 8'h66);
        expect_wr(16'h0010, 8'h11);
        expect_wr(16'h1001, 8'hA5);
        $display("t_indexed done");
    endtask
    task automatic t_pair_ext();
        expect_wr(16'hABCD, 8'hA5);
        expect_wr(16'h3000, 8'hB4);
        $display("t_pair_ext done");
    endtask
    task automatic t_bit();
        expect_wr(16'hABCD, 8'hA7);
        check("bit_zero", 24'h1, {23'h0, bit_zero});
        expect_wr(16'h1001, 8'hA4);
        $display("t_bit done");
    endtask
    // Second index read, stores through the other pairs, arithmetic into A
    task automatic t_mixed();
        expect_wr(16'h5500, 8'h11);
        expect_wr(16'hA7A5, 8'hB6);
        check("bit_zero", 24'h0, {23'h0, bit_zero});
        $display("t_mixed done");
    endtask
    initial begin
        sys_rst = 1'b1;
        run = 1'b1;
        mem_ready = 1'b0;
        mem_rdata = 8'h00;
        stall_q = 1'b0;
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
        for (int i = 0; i < 58; i++) mem[i] = prog[i];
        mem[16'h2000] = 8'hCD;
        mem[16'h2001] = 8'hAB;
        repeat (12) @(negedge ref_clk);
        check("reset outputs", 24'h0, {19'h0, mem_rd_en, mem_wr_en, ofc, instr_done, bit_zero});
        sys_rst = 1'b0;
        t_pointer();
        t_indexed();
        t_pair_ext();
        t_bit();
        t_mixed();
        finish_test();
    end
endmodule
`default_nettype wire
